//--- hdl/power_latency_pkg.sv
// constants for the bridge power and latency control slice
package power_latency_pkg;
  localparam int unsigned OVR_HI = 22;
  localparam int unsigned OVR_LO = 20;
  localparam int unsigned SPEC_OFF_BIT = 19;
  localparam int unsigned SHORT_HI = 18;
  localparam int unsigned SHORT_LO = 16;
  localparam int unsigned DEEP_HI = 15;
  localparam int unsigned DEEP_LO = 13;
  localparam int unsigned VC_BIT = 12;
  localparam int unsigned D3_STOP_BIT = 11;
  localparam int unsigned BEACON_BIT = 10;
  localparam int unsigned CLK_N = 7;
  localparam logic [2:0] OVR_IGNORE = 3'h0;
  localparam logic [2:0] OVR_PIN = 3'h1;
  localparam logic [2:0] OVR_CLK = 3'h2;
  localparam logic [2:0] OVR_CLK_PIN = 3'h3;
  localparam logic [2:0] OVR_UNSUP = 3'h4;
  localparam logic [2:0] LAT_RESET = 3'h0;
  localparam logic OVR_RESET_BIT = 1'h0;
  localparam logic STICKY_RESET = 1'h0;
  typedef enum logic [1:0] {
    RD_PLAIN = 2'h0,
    RD_LINE = 2'h1,
    RD_MULTIPLE = 2'h3
  } mem_read_kind_t;
endpackage : power_latency_pkg

//--- hdl/bridge_power_latency_control.sv
// general control bits 22:10: power override, prefetch, latency, clocks
module bridge_power_latency_control (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic aux_nrst_i,
  input wire logic wr_en_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] wr_mask_i,
  output logic [31:0] rd_data_o,
  input wire logic power_short_i,
  input wire logic [6:0] clock_mask_i,
  input wire logic in_d3_i,
  input wire logic [1:0] read_kind_i,
  input wire logic is_config_or_power_msg_i,
  output logic power_limit_exceeded_pin_o,
  output logic [6:0] secondary_clock_stop_o,
  output logic unsupported_request_o,
  output logic prefetchable_o,
  output logic [2:0] cap_short_idle_exit_o,
  output logic [2:0] cap_deep_idle_exit_o,
  output logic beacon_wake_o
);
  // ********************************************
  // field access helpers
  // ********************************************
  // merge masked write data into a three-bit field
  function automatic logic [2:0] merge3(
      input logic [2:0] old_v,
      input logic [2:0] new_v,
      input logic [2:0] m);
    merge3 = (old_v & ~m) | (new_v & m);
  endfunction : merge3

  // merge masked write data into a single bit
  function automatic logic merge1(
      input logic old_v,
      input logic new_v,
      input logic m);
    merge1 = (old_v & ~m) | (new_v & m);
  endfunction : merge1

  // override codes that raise the pin
  function automatic logic pin_code(
      input logic [2:0] code);
    pin_code = (code == power_latency_pkg::OVR_PIN) ||
        (code == power_latency_pkg::OVR_CLK_PIN);
  endfunction : pin_code

  // override codes that stop masked clocks
  function automatic logic clk_code(
      input logic [2:0] code);
    clk_code = (code == power_latency_pkg::OVR_CLK) ||
        (code == power_latency_pkg::OVR_CLK_PIN);
  endfunction : clk_code

  // override code that refuses transactions
  function automatic logic ur_code(
      input logic [2:0] code);
    ur_code = (code == power_latency_pkg::OVR_UNSUP);
  endfunction : ur_code

  // plain reads lose prefetch when speculation is off
  function automatic logic may_prefetch(
      input logic [1:0] kind,
      input logic spec_off);
    may_prefetch = !spec_off ||
        (kind != power_latency_pkg::RD_PLAIN);
  endfunction : may_prefetch

  // readable word; bit 12 and unused bits read zero
  function automatic logic [31:0] pack_word(
      input logic [2:0] ovr,
      input logic spec_off,
      input logic [2:0] short_lat,
      input logic [2:0] deep_lat,
      input logic d3_stop,
      input logic beacon);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[power_latency_pkg::OVR_HI:power_latency_pkg::OVR_LO] = ovr;
    w[power_latency_pkg::SPEC_OFF_BIT] = spec_off;
    w[power_latency_pkg::SHORT_HI:power_latency_pkg::SHORT_LO] =
        short_lat;
    w[power_latency_pkg::DEEP_HI:power_latency_pkg::DEEP_LO] =
        deep_lat;
    w[power_latency_pkg::VC_BIT] = 1'h0;
    w[power_latency_pkg::D3_STOP_BIT] = d3_stop;
    w[power_latency_pkg::BEACON_BIT] = beacon;
    pack_word = w;
  endfunction : pack_word

  // ********************************************
  // register fields
  // ********************************************
  logic [2:0] ovr_q;
  logic [2:0] ovr_d;
  logic spec_off_q;
  logic spec_off_d;
  logic [2:0] short_q;
  logic [2:0] short_d;
  logic [2:0] deep_q;
  logic [2:0] deep_d;
  logic d3_stop_q;
  logic d3_stop_d;
  logic beacon_q;
  logic beacon_d;
  logic power_short_s1_q;
  logic power_short_q;
  logic pin_q;
  logic [6:0] clk_stop_q;

  // ********************************************
  // write data and mask slices
  // ********************************************
  wire [2:0] ovr_wdata =
      wr_data_i[power_latency_pkg::OVR_HI:power_latency_pkg::OVR_LO];
  wire [2:0] ovr_wmask =
      wr_mask_i[power_latency_pkg::OVR_HI:power_latency_pkg::OVR_LO];
  wire [2:0] short_wdata =
      wr_data_i[power_latency_pkg::SHORT_HI:power_latency_pkg::SHORT_LO];
  wire [2:0] short_wmask =
      wr_mask_i[power_latency_pkg::SHORT_HI:power_latency_pkg::SHORT_LO];
  wire [2:0] deep_wdata =
      wr_data_i[power_latency_pkg::DEEP_HI:power_latency_pkg::DEEP_LO];
  wire [2:0] deep_wmask =
      wr_mask_i[power_latency_pkg::DEEP_HI:power_latency_pkg::DEEP_LO];
  wire spec_off_wdata =
      wr_data_i[power_latency_pkg::SPEC_OFF_BIT];
  wire spec_off_wmask =
      wr_mask_i[power_latency_pkg::SPEC_OFF_BIT];
  wire d3_stop_wdata =
      wr_data_i[power_latency_pkg::D3_STOP_BIT];
  wire d3_stop_wmask =
      wr_mask_i[power_latency_pkg::D3_STOP_BIT];
  wire beacon_wdata =
      wr_data_i[power_latency_pkg::BEACON_BIT];
  wire beacon_wmask =
      wr_mask_i[power_latency_pkg::BEACON_BIT];

  // ********************************************
  // next field values
  // ********************************************
  assign ovr_d = wr_en_i ?
      merge3(ovr_q, ovr_wdata, ovr_wmask) : ovr_q;
  assign short_d = wr_en_i ?
      merge3(short_q, short_wdata, short_wmask) : short_q;
  assign deep_d = wr_en_i ?
      merge3(deep_q, deep_wdata, deep_wmask) : deep_q;
  assign spec_off_d = wr_en_i ?
      merge1(spec_off_q, spec_off_wdata, spec_off_wmask) : spec_off_q;
  assign d3_stop_d = wr_en_i ?
      merge1(d3_stop_q, d3_stop_wdata, d3_stop_wmask) : d3_stop_q;
  assign beacon_d = wr_en_i ?
      merge1(beacon_q, beacon_wdata, beacon_wmask) : beacon_q;

  // ********************************************
  // link, global or power-on reset domain
  // ********************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ovr_q <= power_latency_pkg::OVR_IGNORE;
    end else begin
      ovr_q <= ovr_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      spec_off_q <= power_latency_pkg::OVR_RESET_BIT;
    end else begin
      spec_off_q <= spec_off_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      short_q <= power_latency_pkg::LAT_RESET;
    end else begin
      short_q <= short_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      deep_q <= power_latency_pkg::LAT_RESET;
    end else begin
      deep_q <= deep_d;
    end
  end

  // ********************************************
  // sticky bits, cleared only by auxiliary power-on
  // ********************************************
  always_ff @(posedge clock_i) begin
    if (!aux_nrst_i) begin
      d3_stop_q <= power_latency_pkg::STICKY_RESET;
    end else begin
      d3_stop_q <= d3_stop_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!aux_nrst_i) begin
      beacon_q <= power_latency_pkg::STICKY_RESET;
    end else begin
      beacon_q <= beacon_d;
    end
  end

  // ********************************************
  // slot power status synchroniser
  // ********************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      power_short_s1_q <= 1'h0;
      power_short_q <= 1'h0;
    end else begin
      power_short_s1_q <= power_short_i;
      power_short_q <= power_short_s1_q;
    end
  end

  // ********************************************
  // power override response
  // ********************************************
  wire short_now = power_short_q;
  wire pin_mode = pin_code(ovr_q);
  wire clk_mode = clk_code(ovr_q);
  wire unsup_mode = ur_code(ovr_q);
  wire mask_active = clk_mode && short_now;
  wire d3_active = d3_stop_q && in_d3_i;
  wire pin_d = pin_mode && short_now;
  wire [6:0] clk_stop_d;

  // one stop request per secondary clock
  genvar gi;
  generate
    for (gi = 0; gi < power_latency_pkg::CLK_N; gi = gi + 1) begin : g_clk
      assign clk_stop_d[gi] =
          (mask_active && clock_mask_i[gi]) || d3_active;
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      clk_stop_q <= 7'h00;
    end else begin
      clk_stop_q <= clk_stop_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pin_q <= 1'h0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign power_limit_exceeded_pin_o = pin_q;
  assign secondary_clock_stop_o = clk_stop_q;
  assign unsupported_request_o = unsup_mode && short_now &&
      !is_config_or_power_msg_i;

  // ********************************************
  // prefetch and mirrored fields
  // ********************************************
  assign prefetchable_o =
      may_prefetch(read_kind_i, spec_off_q);
  assign cap_short_idle_exit_o = short_q;
  assign cap_deep_idle_exit_o = deep_q;
  assign beacon_wake_o = beacon_q;

  // ********************************************
  // register read back
  // ********************************************
  assign rd_data_o = pack_word(
      ovr_q,
      spec_off_q,
      short_q,
      deep_q,
      d3_stop_q,
      beacon_q);
endmodule : bridge_power_latency_control

//--- tb/plc_sva.sv
// assertions on the power and latency control slice
module plc_sva (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic in_d3_i,
  input wire logic power_short_i,
  input wire logic [1:0] read_kind_i,
  input wire logic is_config_or_power_msg_i,
  input wire logic [31:0] rd_data_o,
  input wire logic power_limit_exceeded_pin_o,
  input wire logic [6:0] secondary_clock_stop_o,
  input wire logic unsupported_request_o,
  input wire logic prefetchable_o,
  input wire logic [2:0] cap_short_idle_exit_o,
  input wire logic [2:0] cap_deep_idle_exit_o,
  input wire logic beacon_wake_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // short power held in a pin mode, then power restored
  sequence short_held;
    (power_short_i && rd_data_o[20] && !rd_data_o[22])[*3];
  endsequence
  sequence ok_held;
    (!power_short_i)[*3];
  endsequence
  a_pin_on_short: assert property ($rose(power_short_i) ##0 short_held |=>
    power_limit_exceeded_pin_o) else $error("pin not raised");
  a_pin_drops_ok: assert property (ok_held |=> !power_limit_exceeded_pin_o)
    else $error("pin not dropped");
  a_pin_mode_only: assert property (power_limit_exceeded_pin_o |->
    $past(rd_data_o[20]) && !$past(rd_data_o[22])) else $error("pin mode");
  a_stop_cause: assert property (|secondary_clock_stop_o |->
    $past(rd_data_o[22:21]) == 2'h1 || $past(in_d3_i) && $past(rd_data_o[11]))
    else $error("stray clock stop");
  a_d3_stop_all: assert property (in_d3_i && rd_data_o[11] |=>
    secondary_clock_stop_o == 7'h7f) else $error("d3 stop");
  a_ur_cause: assert property (unsupported_request_o |->
    rd_data_o[22:20] == 3'h4 && !is_config_or_power_msg_i) else $error("ur");
  a_prefetch_kind: assert property (read_kind_i != 2'h2 |-> prefetchable_o ==
    (!rd_data_o[19] || read_kind_i != 2'h0)) else $error("prefetch");
  a_idle_mirror: assert property ({cap_short_idle_exit_o,
    cap_deep_idle_exit_o} == rd_data_o[18:13]) else $error("mirror");
  a_fixed_zero: assert property (rd_data_o[31:23] == 9'h0 && !rd_data_o[12]
    && beacon_wake_o == rd_data_o[10]) else $error("fixed bits");
endmodule : plc_sva
bind bridge_power_latency_control plc_sva i_plc_sva (.*);

//--- tb/bridge_power_latency_control_bench.sv
// self-checking bench for the power and latency control slice
module bridge_power_latency_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    bad_count++; $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
  logic clock_i, nrst_i = 0, aux_nrst_i = 0, wr_en_i = 0, power_short_i = 0;
  logic in_d3_i = 0, is_config_or_power_msg_i = 0;
  logic [31:0] wr_data_i = 0, wr_mask_i = 0, rd_data_o;
  logic [6:0] clock_mask_i = 0, secondary_clock_stop_o;
  logic [1:0] read_kind_i = 0;
  logic [2:0] cap_short_idle_exit_o, cap_deep_idle_exit_o;
  logic power_limit_exceeded_pin_o, unsupported_request_o, prefetchable_o;
  logic beacon_wake_o;
  int bad_count = 0, checks_done = 0;
  bridge_power_latency_control i_bridge_power_latency_control (.*);
  initial begin
    clock_i = 0;
    forever #25 clock_i = ~clock_i;
  end
  task cyc(input int n); repeat (n) @(negedge clock_i); endtask : cyc
  task wr(input logic [31:0] d, input logic [31:0] m);
    @(negedge clock_i);
    {wr_en_i, wr_data_i, wr_mask_i} = {1'h1, d, m};
    @(negedge clock_i);
    wr_en_i = 0;
  endtask : wr
  task t_fields;
    `CHK(rd_data_o, 32'h0)
    wr(32'hffffffff, 32'hffffffff);
    `CHK(rd_data_o, 32'h007fec00)
    `CHK({cap_short_idle_exit_o, cap_deep_idle_exit_o}, 6'h3f)
    `CHK({beacon_wake_o, prefetchable_o}, 2'h2)
    read_kind_i = 2'h3;
    #1 `CHK(prefetchable_o, 1'h1)
    wr(32'h0, 32'h00088000);
    read_kind_i = 2'h0;
    #1 `CHK({rd_data_o, prefetchable_o}, {32'h00776c00, 1'h1})
    nrst_i = 0;
    cyc(2);
    nrst_i = 1;
    `CHK(rd_data_o, 32'h00000c00)
    aux_nrst_i = 0;
    cyc(2);
    aux_nrst_i = 1;
    `CHK(rd_data_o, 32'h0)
  endtask : t_fields
  task t_modes;
    clock_mask_i = 7'h55;
    for (int c = 0; c < 6; c++) begin
      wr(32'(c) << 20, 32'hffffffff);
      power_short_i = 1;
      cyc(4);
      `CHK(power_limit_exceeded_pin_o, 1'(c == 1 || c == 3))
      `CHK(secondary_clock_stop_o, (c == 2 || c == 3) ? 7'h55 : 7'h0)
      `CHK(unsupported_request_o, 1'(c == 4))
      is_config_or_power_msg_i = 1;
      #1 `CHK(unsupported_request_o, 1'h0)
      is_config_or_power_msg_i = 0;
      if (c == 3) wr(32'h0, 32'h00700000);
      else power_short_i = 0;
      cyc(4);
      `CHK({power_limit_exceeded_pin_o, secondary_clock_stop_o}, 8'h0)
      power_short_i = 0;
    end
    wr(32'h00000800, 32'h00000800);
    in_d3_i = 1;
    cyc(2);
    `CHK(secondary_clock_stop_o, 7'h7f)
    in_d3_i = 0;
  endtask : t_modes
  task close_out;
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    cyc(4);
    {nrst_i, aux_nrst_i} = 2'h3;
    t_fields;
    t_modes;
    close_out;
  end
endmodule : bridge_power_latency_control_bench
